// file: core/sere_read_engine.sv
// Read engine of a 16-byte serial EEPROM acting as a two-wire bus slave.

// Overview of operation
// R01: A read starts like a write: START, slave address, but direction bit one.
// R02: Counter holds last accessed location plus one for current-address reads.
// R03: After location 15 the counter wraps to location 0 and continues.
// R04: Master does dummy write: START, address with direction zero, byte address.
// R05: After byte address ack, master sends repeated START and read address.
// R06: On read address after dummy write, acknowledge and shift out selected byte.
// R07: Master ends single read with no acknowledge then STOP.
// R08: Sequential read follows either read form; master ack requests more bytes.
// R09: Each master acknowledge after a data byte brings the next sequential byte.
// R10: Sequential read ends on missing master acknowledge then STOP.
// R11: Reads advance all counter bits so whole array reads in one transfer.
// R12: Beyond 16 bytes the counter rolls over and bytes keep coming.
// R13: Match 4-bit type in upper address bits, ignore three, LSB is direction.
// R14: Receiver acknowledges by pulling data low in the ninth clock period.
// R15: On master no-acknowledge release data, stop sending, idle until STOP.
// R16: Four-bit counter, loaded by dummy write, read returns byte then increments.
// R17: Data changes only while clock low, MSB first, released in ack slot.
module sere_read_engine (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic scl,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe_n,
	input wire logic mem_wr_en,
	input wire logic [sere_pkg::ADDR_W-1:0] mem_wr_addr,
	input wire logic [sere_pkg::BYTE_W-1:0] mem_wr_data,
	output logic mem_wr_ready,
	output logic link_busy
);
	import sere_pkg::*;

	// ------------------------------------------------------------------
	// Storage and link-domain reset
	// ------------------------------------------------------------------

	// The array is written on clk and read on the link clock. Writes are
	// only taken while the link is idle, so the read side sees stable data.
	logic [BYTE_W-1:0] mem [DEPTH];

	logic link_rst_meta;
	logic link_rst;

	// Reset is carried into the link domain by two flops; the first feeds only the second.
	always_ff @(negedge scl) begin
		link_rst_meta <= sys_rst;
		link_rst <= link_rst_meta;
	end

	// ------------------------------------------------------------------
	// Rising-edge sampler
	// ------------------------------------------------------------------

	sere_samp_t s;
	sere_samp_t next_s;

	// The data line is captured while the clock is high; the falling edge
	// compares against it to spot a START or a STOP inside the high phase.
	always_comb begin
		next_s = s;
		next_s.psda = sda_in;
	end

	always_ff @(posedge scl) begin
		if (link_rst) begin
			s <= '{psda: SDA_IDLE};
		end else begin
			s <= next_s;
		end
	end

	// ------------------------------------------------------------------
	// Falling-edge protocol engine
	// ------------------------------------------------------------------

	sere_link_t r;
	sere_link_t next_r;
	logic start_cond;
	logic stop_cond;
	logic any_cond;
	logic byte_done;
	logic addr_hit;
	logic [BYTE_W-1:0] rx_byte;
	logic [BYTE_W-1:0] cur_byte;
	logic [ADDR_W-1:0] waddr_lo;
	logic load_evt;

	// Loads the byte at the counter, bumps the counter and puts the MSB on the line.
	function automatic sere_link_t load_next(input sere_link_t cur, input logic [BYTE_W-1:0] data);
		sere_link_t res;
		res = cur;
		res.sh = data;
		res.ctr = cur.ctr + 4'h1; // R02 R03 R11 R12
		res.oe_n = data[MSB];
		res.cnt = CNT_RESET;
		res.st = ST_TX;
		return res;
	endfunction : load_next

	// Line conditions and the byte being received, as seen at this falling edge.
	assign start_cond = s.psda & ~sda_in;
	assign stop_cond = ~s.psda & sda_in;
	assign any_cond = start_cond | stop_cond;
	assign byte_done = (r.cnt == BIT_LAST);
	assign rx_byte = {r.sh[MSB-1:0], sda_in};
	assign waddr_lo = rx_byte[ADDR_W-1:0];
	assign addr_hit = (r.st == ST_ADDR) && byte_done && !any_cond
		&& (rx_byte[TYPE_MSB:TYPE_LSB] == DEV_TYPE);
	assign cur_byte = mem[r.ctr];
	assign load_evt = !any_cond && (((r.st == ST_ACKA) && r.rw) || ((r.st == ST_MACK) && !sda_in));

	// Everything here changes on the falling edge, so the line only moves
	// while the clock is low and the master samples it settled.
	always_comb begin
		next_r = r;
		if (start_cond) begin
			next_r.st = ST_ADDR; // R01
			next_r.cnt = CNT_RESET;
			next_r.oe_n = SDA_IDLE;
		end else if (stop_cond) begin
			next_r.st = ST_IDLE;
			next_r.oe_n = SDA_IDLE;
		end else begin
			unique case (r.st)
				ST_IDLE, ST_WAIT: begin
					next_r.oe_n = SDA_IDLE;
				end
				ST_ADDR: begin
					next_r.sh = rx_byte;
					next_r.cnt = r.cnt + 3'h1;
					if (byte_done) begin
						if (rx_byte[TYPE_MSB:TYPE_LSB] == DEV_TYPE) begin
							next_r.rw = rx_byte[RW_BIT]; // R13
							next_r.oe_n = 1'b0; // R14
							next_r.st = ST_ACKA;
						end else begin
							next_r.st = ST_WAIT;
						end
					end
				end
				ST_ACKA: begin
					if (r.rw) begin
						next_r = load_next(r, cur_byte); // R06 R16
					end else begin
						next_r.oe_n = SDA_IDLE;
						next_r.cnt = CNT_RESET;
						next_r.st = ST_WADDR;
					end
				end
				ST_WADDR: begin
					next_r.sh = rx_byte;
					next_r.cnt = r.cnt + 3'h1;
					if (byte_done) begin
						next_r.ctr = waddr_lo; // R16
						next_r.oe_n = 1'b0; // R14
						next_r.st = ST_ACKW;
					end
				end
				ST_ACKW: begin
					// Write data bytes are not handled here; the engine waits for the repeated START.
					next_r.oe_n = SDA_IDLE;
					next_r.st = ST_WAIT;
				end
				ST_TX: begin
					if (byte_done) begin
						next_r.oe_n = SDA_IDLE; // R17
						next_r.st = ST_MACK;
					end else begin
						next_r.sh = {r.sh[MSB-1:0], 1'b0};
						next_r.oe_n = r.sh[MSB-1]; // R17
						next_r.cnt = r.cnt + 3'h1;
					end
				end
				ST_MACK: begin
					if (!sda_in) begin
						next_r = load_next(r, cur_byte); // R08 R09 R11
					end else begin
						next_r.oe_n = SDA_IDLE; // R10 R15
						next_r.st = ST_WAIT;
					end
				end
				default: begin
					next_r.st = ST_IDLE;
					next_r.oe_n = SDA_IDLE;
				end
			endcase
		end
		next_r.busy = (next_r.st != ST_IDLE) && (next_r.st != ST_WAIT);
	end

	// The counter is four bits, so passing location 15 lands on 0 by itself.
	always_ff @(negedge scl) begin
		if (link_rst) begin
			r <= '{st: ST_IDLE, cnt: CNT_RESET, sh: SH_RESET, ctr: CTR_RESET,
				rw: 1'b0, oe_n: SDA_IDLE, busy: 1'b0}; // R02 R03 R12
		end else begin
			r <= next_r;
		end
	end

	// Open-drain line: the engine only ever pulls low.
	assign sda_out = 1'b0;
	assign sda_oe_n = r.oe_n;

	// ------------------------------------------------------------------
	// System-clock side: array loading and link status
	// ------------------------------------------------------------------

	sere_sys_t q;
	sere_sys_t next_q;

	// Busy level crosses by two flops; the first feeds only the second.
	always_comb begin
		next_q = q;
		next_q.busy_meta = r.busy;
		next_q.busy_sync = q.busy_meta;
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			q <= '{busy_meta: 1'b0, busy_sync: 1'b0};
		end else begin
			q <= next_q;
		end
	end

	// Loads are refused while a transfer runs, which keeps the cross-domain read quiet.
	assign mem_wr_ready = !q.busy_sync && !sys_rst;
	assign link_busy = q.busy_sync;

	// Array loads land on clk; the link side only ever reads the array.
	always_ff @(posedge clk) begin
		if (mem_wr_en && mem_wr_ready) begin
			mem[mem_wr_addr] <= mem_wr_data;
		end
	end

	// ------------------------------------------------------------------
	// Checks on the link engine
	// ------------------------------------------------------------------

	chk_start_restart: assert property (@(negedge scl) disable iff (link_rst) // R01
		start_cond |=> (r.st == ST_ADDR) && r.oe_n && (r.cnt == CNT_RESET))
		else $error("START did not restart address reception");

	chk_addr_ack: assert property (@(negedge scl) disable iff (link_rst) // R13
		addr_hit |=> (r.st == ST_ACKA) && !sda_oe_n ##1 (sda_oe_n || r.st == ST_TX))
		else $error("matching address not acknowledged for one bit");

	chk_addr_miss: assert property (@(negedge scl) disable iff (link_rst) // R13
		((r.st == ST_ADDR) && byte_done && !any_cond && !addr_hit) |=> (r.st == ST_WAIT) && sda_oe_n)
		else $error("foreign address was acknowledged");

	chk_read_byte: assert property (@(negedge scl) disable iff (link_rst) // R16
		load_evt |=> (r.sh == $past(cur_byte)) && (r.ctr == $past(r.ctr) + 4'h1))
		else $error("read did not return counter byte then increment");

	chk_counter_wrap: assert property (@(negedge scl) disable iff (link_rst) // R03
		(load_evt && (r.ctr == 4'hF)) |=> (r.ctr == CTR_RESET))
		else $error("counter did not wrap from 15 to 0");

	chk_waddr_load: assert property (@(negedge scl) disable iff (link_rst) // R16
		((r.st == ST_WADDR) && byte_done && !any_cond) |=> (r.ctr == $past(waddr_lo)) && !sda_oe_n)
		else $error("byte address not loaded into counter");

	chk_msb_first: assert property (@(negedge scl) disable iff (link_rst) // R17
		(r.st == ST_TX) |-> (sda_oe_n == r.sh[MSB]))
		else $error("transmitted bit is not the byte MSB");

	chk_ack_slot_free: assert property (@(negedge scl) disable iff (link_rst) // R17
		(r.st == ST_TX) && (r.cnt == BIT_LAST) && !any_cond |=> (r.st == ST_MACK) && sda_oe_n)
		else $error("data line held during master acknowledge slot");

	chk_next_byte: assert property (@(negedge scl) disable iff (link_rst) // R09
		((r.st == ST_MACK) && !sda_in && !any_cond) |=> (r.st == ST_TX) && (r.cnt == CNT_RESET))
		else $error("master acknowledge did not start next byte");

	chk_nack_idle: assert property (@(negedge scl) disable iff (link_rst) // R15
		((r.st == ST_MACK) && sda_in && !any_cond) |=> (r.st == ST_WAIT) && sda_oe_n ##1 sda_oe_n)
		else $error("engine kept driving after missing acknowledge");

	// The line stays released whenever no bit or acknowledge is owed to the master.
	chk_idle_released: assert property (@(negedge scl) disable iff (link_rst) // R15
		((r.st == ST_IDLE) || (r.st == ST_WAIT)) |-> sda_oe_n)
		else $error("data line pulled while engine idle");

	chk_ctr_kept: assert property (@(negedge scl) disable iff (link_rst) // R02
		(start_cond || stop_cond) |=> (r.ctr == $past(r.ctr)))
		else $error("bus condition disturbed the address counter");

	chk_ackw_release: assert property (@(negedge scl) disable iff (link_rst) // R14
		((r.st == ST_ACKW) && !any_cond) |=> (r.st == ST_WAIT) && sda_oe_n)
		else $error("byte address acknowledge held past its clock");

	chk_tx_bit_step: assert property (@(negedge scl) disable iff (link_rst) // R09
		((r.st == ST_TX) && (r.cnt != BIT_LAST) && !any_cond)
		|=> (r.st == ST_TX) && (r.cnt == $past(r.cnt) + 3'h1))
		else $error("data byte did not advance one bit per clock");

	chk_rw_capture: assert property (@(negedge scl) disable iff (link_rst) // R13
		addr_hit |=> (r.rw == $past(rx_byte[RW_BIT])))
		else $error("direction bit not taken from address byte");

endmodule : sere_read_engine

// file: core/sere_pkg.sv
// Constants, state codes and state records shared by the serial EEPROM read engine.
package sere_pkg;

	// ------------------------------------------------------------------
	// Array geometry
	// ------------------------------------------------------------------
	localparam int ADDR_W = 4;
	localparam int DEPTH = 16;
	localparam int BYTE_W = 8;

	// ------------------------------------------------------------------
	// Slave address layout and byte framing
	// ------------------------------------------------------------------
	// Device-type code; the value is arbitrary.
	localparam logic [3:0] DEV_TYPE = 4'h5;
	localparam int TYPE_MSB = 7;
	localparam int TYPE_LSB = 4;
	localparam int RW_BIT = 0;
	localparam int MSB = 7;
	localparam logic [2:0] BIT_LAST = 3'h7;

	// ------------------------------------------------------------------
	// Reset values
	// ------------------------------------------------------------------
	localparam logic [ADDR_W-1:0] CTR_RESET = 4'h0;
	localparam logic [2:0] CNT_RESET = 3'h0;
	localparam logic [BYTE_W-1:0] SH_RESET = 8'h00;
	localparam logic SDA_IDLE = 1'b1;

	// Link-side states, one-hot.
	typedef enum logic [7:0] {
		ST_IDLE = 8'h01,
		ST_ADDR = 8'h02,
		ST_ACKA = 8'h04,
		ST_WADDR = 8'h08,
		ST_ACKW = 8'h10,
		ST_TX = 8'h20,
		ST_MACK = 8'h40,
		ST_WAIT = 8'h80
	} sere_state_t;

	// State clocked on the falling edge of the link clock.
	typedef struct packed {
		sere_state_t st;
		logic [2:0] cnt;
		logic [BYTE_W-1:0] sh;
		logic [ADDR_W-1:0] ctr;
		logic rw;
		logic oe_n;
		logic busy;
	} sere_link_t;

	// State clocked on the rising edge of the link clock.
	typedef struct packed {
		logic psda;
	} sere_samp_t;

	// State clocked on the system clock.
	typedef struct packed {
		logic busy_meta;
		logic busy_sync;
	} sere_sys_t;

endpackage : sere_pkg

// file: tb/sere_master.sv
// Two-wire bus master model that drives the serial clock and its side of the data wire.
module sere_master (
	output logic scl,
	output logic sda_m,
	input wire logic sda
);
	timeunit 1ns;
	timeprecision 100ps;

	// ----------------------------------------
	// Bit and condition level
	// ----------------------------------------
	// The clock stands low between frames, so no stray edge reaches the engine.
	initial begin
		scl = 1'b0;
		sda_m = 1'b1;
	end

	// Data changes only while the clock is low; the wire is sampled at the rising edge.
	task automatic bit_xfer(input logic b, output logic s);
		sda_m = b;
		#1.5 scl = 1'b1;
		s = sda;
		#3 scl = 1'b0;
		#1.5;
	endtask : bit_xfer

	task automatic clocks(input int n);
		logic s;
		repeat (n) bit_xfer(1'b1, s);
	endtask : clocks

	task automatic start();
		sda_m = 1'b1;
		#1.5 scl = 1'b1;
		#1.5 sda_m = 1'b0;
		#1.5 scl = 1'b0;
		#1.5;
	endtask : start

	// The engine sees the STOP at the falling edge inside this task; one extra idle clock follows it.
	task automatic stop();
		sda_m = 1'b0;
		#1.5 scl = 1'b1;
		#1.5 sda_m = 1'b1;
		#1.5 scl = 1'b0;
		#1.5;
		clocks(1);
	endtask : stop

	task automatic put_byte(input logic [7:0] d, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--) bit_xfer(d[i], s);
		bit_xfer(1'b1, ack);
	endtask : put_byte

	task automatic get_byte(input logic nack, output logic [7:0] d, output logic s);
		for (int i = 7; i >= 0; i--) bit_xfer(1'b1, d[i]);
		bit_xfer(nack, s);
	endtask : get_byte
endmodule : sere_master

// file: tb/sere_read_engine_bench.sv
// Self-checking testbench of the serial EEPROM read engine.
module sere_read_engine_bench;
	timeunit 1ns;
	timeprecision 100ps;
	import sere_pkg::*;

	logic clk, sys_rst, scl, sda_m, sda_out, sda_oe_n, mem_wr_en, mem_wr_ready, link_busy;
	wire logic sda;
	logic [ADDR_W-1:0] mem_wr_addr;
	logic [BYTE_W-1:0] mem_wr_data;
	logic [BYTE_W-1:0] mem [DEPTH];
	logic [ADDR_W-1:0] ectr;
	int error_cnt, checks;

	// ----------------------------------------
	// Clock, wire and instances
	// ----------------------------------------
	// The pull-up gives a high wire unless a party pulls it low.
	always #2.5 clk = ~clk;
	assign sda = sda_m & (sda_oe_n | sda_out);

	sere_master u_m (.scl(scl), .sda_m(sda_m), .sda(sda));
	sere_read_engine u_dut (.clk(clk), .sys_rst(sys_rst), .scl(scl), .sda_in(sda), .sda_out(sda_out),
		.sda_oe_n(sda_oe_n), .mem_wr_en(mem_wr_en), .mem_wr_addr(mem_wr_addr),
		.mem_wr_data(mem_wr_data), .mem_wr_ready(mem_wr_ready), .link_busy(link_busy));

	// ----------------------------------------
	// Checks and bus tasks
	// ----------------------------------------
	task automatic cmp1(input string what, input logic e, input logic g);
		checks++;
		if (g !== e) begin
			error_cnt++;
			$display("BAD %s expected %b seen %b", what, e, g);
		end
	endtask : cmp1

	task automatic cmp8(input string what, input logic [7:0] e, input logic [7:0] g);
		checks++;
		if (g !== e) begin
			error_cnt++;
			$display("BAD %s expected %h seen %h", what, e, g);
		end
	endtask : cmp8

	task automatic close_out();
		if (error_cnt == 0 && checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : close_out

	// Loads wait for the link to go idle, since the array is locked during a transfer.
	task automatic load(input logic [ADDR_W-1:0] a, input logic [BYTE_W-1:0] d);
		int n;
		n = 0;
		@(negedge clk);
		while (mem_wr_ready !== 1'b1 && n < 100) begin
			@(negedge clk);
			n++;
		end
		if (n == 100) begin
			error_cnt++;
			close_out();
		end
		mem_wr_en = 1'b1;
		mem_wr_addr = a;
		mem_wr_data = d;
		@(negedge clk);
		mem_wr_en = 1'b0;
		mem[a] = d;
	endtask : load

	// A dummy write selects the start location; without it the counter carries on.
	task automatic read_run(input bit sel, input logic [ADDR_W-1:0] a, input int n);
		logic s;
		logic [BYTE_W-1:0] d;
		if (sel) begin
			u_m.start();
			u_m.put_byte({DEV_TYPE, 3'($urandom), 1'b0}, s);
			cmp1("ack_waddr", 1'b0, s);
			u_m.put_byte({4'($urandom), a}, s);
			cmp1("ack_baddr", 1'b0, s);
			ectr = a;
		end
		u_m.start();
		u_m.put_byte({DEV_TYPE, 3'($urandom), 1'b1}, s);
		cmp1("ack_raddr", 1'b0, s);
		cmp1("link_busy", 1'b1, link_busy);
		cmp1("wr_locked", 1'b0, mem_wr_ready);
		for (int i = 0; i < n; i++) begin
			u_m.get_byte(i == n - 1, d, s);
			cmp8("rd_data", mem[ectr], d);
			cmp1("ack_slot", i == n - 1, s);
			ectr++;
		end
		u_m.bit_xfer(1'b1, s);
		cmp1("after_nack", 1'b1, s);
		u_m.stop();
	endtask : read_run

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		logic s;
		clk = 1'b0;
		sys_rst = 1'b1;
		mem_wr_en = 1'b0;
		mem_wr_addr = 4'h0;
		mem_wr_data = 8'h00;
		error_cnt = 0;
		checks = 0;
		void'($urandom(38));
		// The link clock must run during reset so the link side sees it.
		fork
			repeat (20) @(negedge clk);
			u_m.clocks(20);
		join
		@(negedge clk);
		sys_rst = 1'b0;
		u_m.clocks(4);
		for (int i = 0; i < DEPTH; i++) load(4'(i), i == 0 ? 8'hFF : i == 15 ? 8'h00 : 8'($urandom));
		read_run(1'b1, 4'hF, 18);
		read_run(1'b0, 4'h0, 2);
		u_m.start();
		u_m.put_byte({DEV_TYPE ^ 4'(1 + $urandom % 15), 4'($urandom)}, s);
		cmp1("ack_foreign", 1'b1, s);
		u_m.stop();
		repeat (6) read_run(1'($urandom), 4'($urandom), 1 + $urandom % 4);
		for (int i = 0; i < 3; i++) begin
			load(4'(i * 7), 8'($urandom));
			read_run(1'b1, 4'(i * 7), 1);
		end
		close_out();
	end
endmodule : sere_read_engine_bench
